// file: include/nocb_pkg.sv
// Package: constants, settings and carrier types of one overcurrent stage
package nocb_pkg;
    // Clock and processing cycle timing
    localparam int CLK_NS = 100;
    localparam int CYCLE_US = 5000;
    localparam int CYCLE_CLKS = CYCLE_US * 1000 / CLK_NS;
    localparam int CYCLE_MS = 5;
    localparam int PRE_TRIG_MS = 20;
    localparam int PRE_FAULT_MS = 200;
    localparam int PRE_TRIG_CYC = PRE_TRIG_MS / CYCLE_MS;
    localparam int PRE_FAULT_CYC = PRE_FAULT_MS / CYCLE_MS;
    // Ratios in hundredths, and the depth of the fault log
    localparam int RESET_PCT = 97;
    localparam int PCT_FULL = 100;
    localparam int LOG_DEPTH = 12;
    // Widths
    localparam int MAG_W = 16;
    localparam int TIME_W = 20;
    localparam int CNT_W = 16;
    localparam int TS_W = 32;
    localparam int TICK_W = 16;
    localparam int NUM_EV = 9;
    localparam int EVSEL_ON_BIT = 0;
    localparam int EVSEL_OFF_BIT = 1;
    localparam logic [MAG_W-1:0] RATIO_SAT = 16'hFFFF;

    typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} nocb_cond_t;
    typedef enum logic {DLY_FIXED, DLY_INVERSE} nocb_dly_t;
    // Event sources, index into the flag vector
    typedef enum logic [3:0] {EV_START, EV_TRIP, EV_BLOCK, EV_START_A, EV_START_B,
        EV_START_C, EV_TRIP_A, EV_TRIP_B, EV_TRIP_C} nocb_evsrc_t;

    typedef struct packed {
        logic [2:0][MAG_W-1:0] mag;     // Phase magnitudes A..C
        logic [MAG_W-1:0] harm_ratio;   // 2nd harmonic / fundamental, 0.01 %
    } nocb_meas_t;

    typedef struct packed {
        logic [MAG_W-1:0] iset;          // Pick-up level
        nocb_dly_t dly_type;
        logic [TIME_W-1:0] fixed_steps;  // Fixed / minimum delay, 5 ms steps
        logic [TIME_W-1:0] inv_k;        // Inverse time multiplier, 5 ms steps
        logic [TIME_W-1:0] release_steps;
        logic inrush_en;
        logic [MAG_W-1:0] harm_limit;    // 0.01 % of fundamental
        logic [1:0] ev_sel;              // Bit 0 ON events, bit 1 OFF events
        logic [2:0] setting_group;
    } nocb_cfg_t;

    typedef struct packed {
        nocb_cond_t cond;
        logic [2:0] phase_start;
        logic [2:0] phase_trip;
        logic [TIME_W-1:0] expected;     // 5 ms steps
        logic signed [TIME_W:0] remaining;
        logic [MAG_W-1:0] ratio;         // Imax / Iset in 0.01
    } nocb_status_t;

    typedef struct packed {
        logic valid;
        nocb_evsrc_t src;
        logic on;
        logic [TS_W-1:0] stamp;
    } nocb_event_t;

    typedef struct packed {
        logic [CNT_W-1:0] starts;
        logic [CNT_W-1:0] trips;
        logic [CNT_W-1:0] blocks;
    } nocb_count_t;

    typedef struct packed {
        logic [TS_W-1:0] stamp;
        nocb_cond_t event_kind;
        logic [2:0] fault_phases;
        logic [MAG_W-1:0] pre_trig;
        logic [MAG_W-1:0] fault_cur;
        logic [MAG_W-1:0] pre_fault;
        logic [TIME_W-1:0] remaining;
        logic [2:0] setting_group;
    } nocb_rec_t;
endpackage

// file: logic/nocb_stage.sv
// Design: status, blocking, timing, events, counters and fault log of one overcurrent stage
// Overview of operation
// [RULE_01] Blocking input is sampled at every processing tick before pick-up is evaluated.
// [RULE_02] Pick-up without blocking asserts start and begins operate timing.
// [RULE_03] Pick-up with blocking present asserts blocked; no start or trip follows.
// [RULE_04] Blocking during start drops start and runs the normal release behaviour.
// [RULE_05] Blocking source must assert at least 5 ms before the delay expires.
// [RULE_06] Optional second-harmonic inrush blocking, off by default, inhibits only tripping.
// [RULE_07] Inrush limit is a harmonic/fundamental ratio in 0.01 % steps.
// [RULE_08] Delay is either fixed time or inverse time with definite minimum.
// [RULE_09] Expected operating time in 5 ms steps, following highest phase current.
// [RULE_10] Remaining time to trip counts down in 5 ms steps while timing.
// [RULE_11] Highest phase current over pick-up level reported in 0.01 steps.
// [RULE_12] Overall condition and per-phase start/trip condition are reported.
// [RULE_13] Separate ON/OFF events for start, trip, block and per-phase start/trip.
// [RULE_14] Setting selects ON, OFF or both events for the event buffer.
// [RULE_15] Each event carries the time stamp of its status change.
// [RULE_16] Cumulative start, trip and blocked counters, clearable on request.
// [RULE_17] Twelve most recent records kept, oldest overwritten.
// [RULE_18] Record holds stamp, event, phases, -20 ms, fault, -200 ms, remaining, group.
// [RULE_19] Pick-up above level, releases only below 97 % of level.
// [RULE_20] Enabled inrush blocking acts while harmonic ratio is at or above limit.
`timescale 1ns/1ps
`default_nettype none
module nocb_stage
    import nocb_pkg::*;
#(
    parameter int CYCLE_CLOCKS = CYCLE_CLKS
) (
    input wire logic clk,
    input wire logic rst,
    input wire nocb_meas_t meas,
    input wire nocb_cfg_t cfg,
    input wire logic block_in,
    input wire logic [TS_W-1:0] timestamp,
    input wire logic cnt_clear,
    input wire logic [3:0] log_sel,
    output nocb_status_t status,
    output nocb_event_t event_out,
    output nocb_count_t counts,
    output nocb_rec_t log_rec,
    output logic [3:0] log_count
);
    typedef struct packed {
        logic blk_meta;
        logic blk_sync;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic blk_smp;
        logic [2:0] pick;
        logic started;
        logic tripped;
        logic blocked;
        logic inrush_hit;
        logic releasing;
        logic [TIME_W-1:0] elapsed;
        logic [TIME_W-1:0] rel_cnt;
        logic [PRE_FAULT_CYC-1:0][MAG_W-1:0] hist;
        nocb_status_t status;
        logic [NUM_EV-1:0] prev_flags;
        logic [NUM_EV-1:0] pend;
        logic [NUM_EV-1:0] pend_on;
        logic [TS_W-1:0] stamp;
        nocb_event_t ev;
        nocb_count_t cnt;
        logic [LOG_DEPTH-1:0][$bits(nocb_rec_t)-1:0] log;
        logic [3:0] wr_ptr;
        logic [3:0] fill;
        nocb_rec_t log_out;
    } nocb_state_t;

    nocb_state_t st;
    nocb_state_t next_st;

    // Largest of the three phase magnitudes
    function automatic logic [MAG_W-1:0] max3(input logic [2:0][MAG_W-1:0] m);
        logic [MAG_W-1:0] r;
        r = m[0];
        if (m[1] > r) begin
            r = m[1];
        end
        if (m[2] > r) begin
            r = m[2];
        end
        return r;
    endfunction

    // Lowest pending event index
    function automatic logic [3:0] first_set(input logic [NUM_EV-1:0] v);
        logic [3:0] r;
        r = '0;
        for (int i = NUM_EV - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Ring slot of the record sel places back from the newest
    function automatic logic [3:0] ring_slot(input logic [3:0] wp, input logic [3:0] sel);
        int s;
        s = int'(wp) - 1 - int'(sel);
        if (s < 0) begin
            s = s + LOG_DEPTH;
        end
        return 4'(s);
    endfunction

    logic [MAG_W-1:0] imax;
    logic [31:0] ratio_wide;
    logic [MAG_W-1:0] ratio;
    logic [31:0] inv_wide;
    logic [TIME_W-1:0] expected;
    logic [2:0] pick_now;
    logic any_pick;
    logic [NUM_EV-1:0] flags;
    logic [NUM_EV-1:0] change;
    nocb_rec_t rec;

    // Measured ratio and expected operating time
    always_comb begin
        imax = max3(meas.mag);
        if (cfg.iset == '0) begin
            ratio_wide = 32'hFFFF_FFFF;
        end else begin
            ratio_wide = (32'(imax) * 32'(PCT_FULL)) / 32'(cfg.iset);
        end
        ratio = (ratio_wide > 32'(RATIO_SAT)) ? RATIO_SAT : ratio_wide[MAG_W-1:0]; // [RULE_11]
        // Inverse curve with the fixed delay as its definite minimum
        if (ratio_wide > 32'(PCT_FULL)) begin
            inv_wide = (32'(cfg.inv_k) * 32'(PCT_FULL)) / (ratio_wide - 32'(PCT_FULL));
        end else begin
            inv_wide = 32'hFFFF_FFFF;
        end
        if (inv_wide > 32'((1 << TIME_W) - 1)) begin
            inv_wide = 32'((1 << TIME_W) - 1);
        end
        if (cfg.dly_type == DLY_INVERSE && inv_wide > 32'(cfg.fixed_steps)) begin
            expected = inv_wide[TIME_W-1:0]; // [RULE_08] [RULE_09]
        end else begin
            expected = cfg.fixed_steps; // [RULE_08]
        end
    end

    // Per-phase pick-up with built-in 97 % reset ratio
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            if (meas.mag[p] > cfg.iset) begin
                pick_now[p] = 1'b1; // [RULE_19]
            end else if (32'(meas.mag[p]) * 32'(PCT_FULL) < 32'(cfg.iset) * 32'(RESET_PCT)) begin
                pick_now[p] = 1'b0; // [RULE_19]
            end else begin
                pick_now[p] = st.pick[p];
            end
        end
        any_pick = |pick_now;
    end

    // Next state of the whole stage
    always_comb begin
        next_st = st;
        next_st.ev.valid = 1'b0;
        // Two flops on the blocking matrix input
        next_st.blk_meta = block_in;
        next_st.blk_sync = st.blk_meta;
        next_st.tick = 1'b0;
        flags = '0;
        change = '0;
        rec = '0;
        if (st.tick_cnt >= TICK_W'(CYCLE_CLOCKS - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 1'b1;
        end
        if (st.tick) begin
            next_st.blk_smp = st.blk_sync; // [RULE_01]
            next_st.pick = pick_now;
            next_st.inrush_hit = cfg.inrush_en && (meas.harm_ratio >= cfg.harm_limit); // [RULE_20] [RULE_07]
            next_st.hist = {st.hist[PRE_FAULT_CYC-2:0], imax};
            if (!any_pick) begin
                next_st.blocked = 1'b0;
                next_st.tripped = 1'b0;
                if (st.started) begin
                    next_st.started = 1'b0;
                    next_st.releasing = 1'b1;
                    next_st.rel_cnt = '0;
                end
            end else if (st.blocked) begin
                next_st.blocked = 1'b1; // [RULE_03]
            end else if (st.started && st.blk_sync) begin
                next_st.started = 1'b0; // [RULE_04]
                next_st.tripped = 1'b0;
                next_st.releasing = 1'b1; // [RULE_04]
                next_st.rel_cnt = '0;
            end else if (!st.started && !st.tripped) begin
                if (st.blk_sync) begin
                    next_st.blocked = 1'b1; // [RULE_03]
                end else begin
                    next_st.started = 1'b1; // [RULE_02]
                    next_st.releasing = 1'b0;
                end
            end else if (st.started && !st.tripped) begin
                // Inrush holds the timer short of tripping, start stays visible
                if (st.elapsed + 1'b1 >= expected) begin
                    next_st.elapsed = expected;
                    next_st.tripped = !next_st.inrush_hit; // [RULE_06]
                end else begin
                    next_st.elapsed = st.elapsed + 1'b1; // [RULE_02]
                end
            end
            // Release time holds the elapsed count, then clears it
            if (st.releasing && !next_st.started) begin
                if (st.rel_cnt >= cfg.release_steps) begin
                    next_st.releasing = 1'b0;
                    next_st.elapsed = '0;
                end else begin
                    next_st.rel_cnt = st.rel_cnt + 1'b1;
                end
            end
            // Published status
            next_st.status.ratio = ratio; // [RULE_11]
            next_st.status.expected = expected; // [RULE_09]
            if (next_st.started && !next_st.tripped) begin
                next_st.status.remaining = $signed({1'b0, expected}) - $signed({1'b0, next_st.elapsed}); // [RULE_10]
            end else begin
                next_st.status.remaining = '0;
            end
            next_st.status.phase_start = pick_now & {3{next_st.started}}; // [RULE_12]
            next_st.status.phase_trip = pick_now & {3{next_st.tripped}}; // [RULE_12]
            if (next_st.tripped) begin
                next_st.status.cond = COND_TRIP;
            end else if (next_st.blocked) begin
                next_st.status.cond = COND_BLOCKED;
            end else if (next_st.started) begin
                next_st.status.cond = COND_START;
            end else begin
                next_st.status.cond = COND_NORMAL; // [RULE_12]
            end
            // Status changes become pending events, stamped at this tick
            flags = {next_st.status.phase_trip, next_st.status.phase_start,
                next_st.blocked, next_st.tripped, next_st.started};
            change = flags ^ st.prev_flags; // [RULE_13]
            next_st.prev_flags = flags;
            next_st.pend = change & (flags & {NUM_EV{cfg.ev_sel[EVSEL_ON_BIT]}}
                | ~flags & {NUM_EV{cfg.ev_sel[EVSEL_OFF_BIT]}}); // [RULE_14]
            next_st.pend_on = flags;
            next_st.stamp = timestamp; // [RULE_15]
            // Fault record on start, trip or blocked ON
            if (change[EV_START] | change[EV_TRIP] | change[EV_BLOCK]) begin
                rec.stamp = timestamp; // [RULE_18]
                rec.event_kind = next_st.status.cond;
                rec.fault_phases = pick_now;
                rec.pre_trig = st.hist[PRE_TRIG_CYC-1];
                rec.fault_cur = imax;
                rec.pre_fault = st.hist[PRE_FAULT_CYC-1];
                rec.remaining = next_st.status.remaining[TIME_W-1:0];
                rec.setting_group = cfg.setting_group;
                if (flags[EV_START] & change[EV_START] | flags[EV_TRIP] & change[EV_TRIP]
                    | flags[EV_BLOCK] & change[EV_BLOCK]) begin
                    next_st.log[st.wr_ptr] = rec; // [RULE_17]
                    next_st.wr_ptr = (st.wr_ptr == 4'(LOG_DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
                    next_st.fill = (st.fill == 4'(LOG_DEPTH)) ? st.fill : st.fill + 1'b1;
                end
            end
            // Counters: a new occurrence wins over a clear in the same cycle
            next_st.cnt.starts = (cnt_clear ? '0 : st.cnt.starts)
                + CNT_W'(flags[EV_START] & change[EV_START]); // [RULE_16]
            next_st.cnt.trips = (cnt_clear ? '0 : st.cnt.trips)
                + CNT_W'(flags[EV_TRIP] & change[EV_TRIP]);
            next_st.cnt.blocks = (cnt_clear ? '0 : st.cnt.blocks)
                + CNT_W'(flags[EV_BLOCK] & change[EV_BLOCK]);
        end else begin
            if (cnt_clear) begin
                next_st.cnt = '0; // [RULE_16]
            end
            // Drain one pending event per clock; the tick period is far longer
            if (|st.pend) begin
                next_st.ev.valid = 1'b1;
                next_st.ev.src = nocb_evsrc_t'(first_set(st.pend));
                next_st.ev.on = st.pend_on[first_set(st.pend)];
                next_st.ev.stamp = st.stamp; // [RULE_15]
                next_st.pend[first_set(st.pend)] = 1'b0;
            end
        end
        next_st.log_out = st.log[ring_slot(st.wr_ptr, log_sel)];
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign status = st.status;
    assign event_out = st.ev;
    assign counts = st.cnt;
    assign log_rec = st.log_out;
    assign log_count = st.fill;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_block_sample: assert property (st.tick && any_pick && !st.blocked && !st.started
        && !st.tripped |=> st.blocked == st.blk_smp) // [RULE_01]
        else $error("blocking not sampled at tick");
    chk_start_clean: assert property (st.tick && any_pick && !st.blk_sync && !st.blocked
        && !st.started && !st.tripped |=> st.started && st.status.cond == COND_START) // [RULE_02]
        else $error("start missing on unblocked pick-up");
    chk_blocked_entry: assert property (st.tick && any_pick && st.blk_sync && !st.started
        && !st.tripped |=> st.blocked && !st.started ##1 !st.tripped) // [RULE_03]
        else $error("blocked pick-up not held off");
    chk_block_drops: assert property (st.tick && any_pick && st.started && st.blk_sync
        && !st.blocked |=> !st.started && st.releasing) // [RULE_04]
        else $error("start not dropped by blocking");
    chk_inrush_trip: assert property (st.tick && st.started && !st.tripped && cfg.inrush_en
        && meas.harm_ratio >= cfg.harm_limit |=> !st.tripped) // [RULE_06]
        else $error("trip despite inrush");
    chk_trip_timing: assert property ($rose(st.tripped) |-> st.elapsed == st.status.expected) // [RULE_08]
        else $error("trip before delay");
    chk_remain_count: assert property (st.started && !st.tripped
        |-> st.status.remaining == $signed({1'b0, st.status.expected}) - $signed({1'b0, st.elapsed})) // [RULE_10]
        else $error("remaining time wrong");
    chk_event_select: assert property (st.ev.valid |-> (st.ev.on ? cfg.ev_sel[EVSEL_ON_BIT]
        : cfg.ev_sel[EVSEL_OFF_BIT]) || $changed(cfg.ev_sel)) // [RULE_14]
        else $error("unselected event emitted");
    chk_count_clear: assert property (cnt_clear && !st.tick |=> st.cnt == '0) // [RULE_16]
        else $error("counter clear ignored");
    chk_log_ring: assert property (st.wr_ptr < 4'(LOG_DEPTH) && st.fill <= 4'(LOG_DEPTH)) // [RULE_17]
        else $error("log pointer out of range");
    chk_pick_hyst: assert property (st.tick && st.pick[0] && meas.mag[0] <= cfg.iset
        && 32'(meas.mag[0]) * 32'(PCT_FULL) >= 32'(cfg.iset) * 32'(RESET_PCT) |=> st.pick[0]) // [RULE_19]
        else $error("pick-up released inside hysteresis");

    cov_trip: cover property ($rose(st.tripped));
    cov_blocked: cover property ($rose(st.blocked));
    cov_block_drop: cover property (st.started ##1 st.releasing && !st.started);
    cov_log_wrap: cover property (st.fill == 4'(LOG_DEPTH) && $changed(st.wr_ptr));
endmodule // nocb_stage
`default_nettype wire

// file: verification/nocb_front_model.sv
// Model of the current measurement front end and blocking matrix feeding one stage
`timescale 1ns/1ps
`default_nettype none
module nocb_front_model
    import nocb_pkg::*;
(
    input wire logic clk,
    input wire logic [MAG_W-1:0] cmd_mag,
    input wire logic [2:0] cmd_phases,
    input wire logic [MAG_W-1:0] cmd_harm,
    input wire logic cmd_block,
    output var nocb_meas_t meas,
    output var logic block_in
);
    // New levels appear just after a rising edge; one process owns both outputs
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            meas.mag[i] <= cmd_phases[i] ? cmd_mag : 16'h0000;
        end
        meas.harm_ratio <= cmd_harm;
        // Requests arrive half a cycle ahead of a tick, far inside the 5 ms margin
        block_in <= cmd_block;
    end
endmodule // nocb_front_model
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for one overcurrent stage with its front end model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nocb_pkg::*;
    localparam int CC = 20; // Short processing cycle keeps the run brief
    logic clk = 1'b0;
    logic rst = 1'b1;
    nocb_cfg_t cfg = '0;
    logic [TS_W-1:0] timestamp = 32'h0000_0000;
    logic cnt_clear = 1'b0;
    logic [3:0] log_sel = 4'h0;
    logic [MAG_W-1:0] cmd_mag = 16'h0000;
    logic [2:0] cmd_phases = 3'h1;
    logic [MAG_W-1:0] cmd_harm = 16'hFFFF;
    logic cmd_block = 1'b0;
    nocb_meas_t meas;
    logic block_in;
    nocb_status_t status;
    nocb_event_t event_out;
    nocb_count_t counts;
    nocb_rec_t log_rec;
    logic [3:0] log_count;
    int num_errors = 0;
    int check_count = 0;
    int lag = 0;
    logic [12:0] ev_q[$];
    logic [7:0] ts_q[$];
    logic [7:0] t0;

    initial begin
        forever #50 clk = ~clk;
    end

    nocb_front_model nocb_front_model_inst (.clk(clk), .cmd_mag(cmd_mag),
        .cmd_phases(cmd_phases), .cmd_harm(cmd_harm), .cmd_block(cmd_block),
        .meas(meas), .block_in(block_in));
    nocb_stage #(.CYCLE_CLOCKS(CC)) nocb_stage_inst (.clk(clk), .rst(rst), .meas(meas),
        .cfg(cfg), .block_in(block_in), .timestamp(timestamp), .cnt_clear(cnt_clear),
        .log_sel(log_sel), .status(status), .event_out(event_out), .counts(counts),
        .log_rec(log_rec), .log_count(log_count));

    // Every event pulse is queued; scenarios inspect the queue in bulk
    always @(posedge clk) begin
        if (event_out.valid === 1'b1) begin
            ev_q.push_back({event_out.stamp[7:0], event_out.src, event_out.on});
        end
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic [4:0] ev(input nocb_evsrc_t s, input logic o);
        return {s, o};
    endfunction

    task automatic check_ev(input logic [7:0] t, input logic [4:0] exp[$]);
        check(ev_q.size(), exp.size());
        foreach (exp[i]) begin
            if (i < ev_q.size()) begin
                check(ev_q[i], {t, exp[i]});
            end
        end
        ev_q.delete();
    endtask

    // Stepping whole cycles keeps the bench parked midway between ticks
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (CC - lag) @(negedge clk);
            lag = 0;
            timestamp = timestamp + 32'h0000_0001;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
        lag += n;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the roughly 60 ticks of the sequence
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        cfg.iset = 16'h03E8;
        cfg.fixed_steps = 20'h0_0003;
        cfg.inv_k = 20'h0_0064;
        cfg.harm_limit = 16'h05DC;
        cfg.ev_sel = 2'h3;
        cfg.setting_group = 3'h5;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (CC / 2) @(negedge clk);
        check(status, '0);
        // Fixed delay on phase A; harmonic is high but the inrush option is off
        t0 = timestamp[7:0];
        cmd_mag = 16'h05DC;
        ticks(1);
        check(status.cond, COND_START);
        check(status.phase_start, 3'h1);
        check(status.expected, 20'h0_0003);
        check(status.remaining, 21'h0_0003);
        check(status.ratio, 16'h0096);
        check_ev(t0, '{ev(EV_START, 1'b1), ev(EV_START_A, 1'b1)});
        ticks(1);
        check(status.remaining, 21'h0_0002);
        ticks(2);
        check(status.cond, COND_TRIP);
        check(status.phase_trip, 3'h1);
        check_ev(t0 + 8'h03, '{ev(EV_TRIP, 1'b1), ev(EV_TRIP_A, 1'b1)});
        check(counts, {16'h0001, 16'h0001, 16'h0000});
        check(log_count, 4'h2);
        log_sel = 4'h1;
        idle(2);
        check(log_rec.event_kind, COND_START);
        check(log_rec.stamp[7:0], t0);
        check(log_rec.fault_phases, 3'h1);
        check(log_rec.fault_cur, 16'h05DC);
        check(log_rec.pre_trig, 16'h0000);
        check(log_rec.remaining, 20'h0_0003);
        check(log_rec.setting_group, 3'h5);
        log_sel = 4'h0;
        // Above the 97 % release level the trip holds; below it all clears
        cmd_mag = 16'h03D6;
        ticks(1);
        check(status.cond, COND_TRIP);
        t0 = timestamp[7:0];
        cmd_mag = 16'h03C0;
        ticks(1);
        check(status.cond, COND_NORMAL);
        check_ev(t0, '{ev(EV_START, 1'b0), ev(EV_TRIP, 1'b0),
            ev(EV_START_A, 1'b0), ev(EV_TRIP_A, 1'b0)});
        // ON-only, then OFF-only event selection
        for (int s = 1; s < 3; s++) begin
            cfg.ev_sel = s[1:0];
            t0 = timestamp[7:0];
            cmd_mag = 16'h05DC;
            ticks(1);
            cmd_mag = 16'h0000;
            ticks(1);
            if (s == 1) begin
                check_ev(t0, '{ev(EV_START, 1'b1), ev(EV_START_A, 1'b1)});
            end else begin
                check_ev(t0 + 8'h01, '{ev(EV_START, 1'b0), ev(EV_START_A, 1'b0)});
            end
        end
        cfg.ev_sel = 2'h3;
        // Block and pick-up land in the same cycle: blocked, never started or tripped
        t0 = timestamp[7:0];
        cmd_block = 1'b1;
        cmd_mag = 16'h05DC;
        ticks(1);
        check(status.cond, COND_BLOCKED);
        check(status.phase_start, 3'h0);
        ticks(4);
        check(status.cond, COND_BLOCKED);
        check_ev(t0, '{ev(EV_BLOCK, 1'b1)});
        check(counts.blocks, 16'h0001);
        cmd_block = 1'b0;
        cmd_mag = 16'h0000;
        ticks(1);
        check(status.cond, COND_NORMAL);
        // Block arriving during start drops it and keeps the trip away
        cmd_mag = 16'h05DC;
        ticks(1);
        cmd_block = 1'b1;
        ticks(3);
        check(status.cond, COND_BLOCKED);
        check(status.phase_start, 3'h0);
        check(counts.trips, 16'h0001);
        cmd_block = 1'b0;
        cmd_mag = 16'h0000;
        ticks(1);
        // Harmonic exactly at the limit holds the trip; one step below releases it
        cfg.inrush_en = 1'b1;
        cmd_harm = 16'h05DC;
        cmd_mag = 16'h05DC;
        ticks(5);
        check(status.cond, COND_START);
        cmd_harm = 16'h05DB;
        ticks(1);
        check(status.cond, COND_TRIP);
        cmd_mag = 16'h0000;
        cfg.inrush_en = 1'b0;
        ticks(1);
        // Inverse delay follows the highest current as it changes
        cfg.dly_type = DLY_INVERSE;
        cfg.fixed_steps = 20'h0_0002;
        cmd_mag = 16'h07D0;
        ticks(1);
        check(status.expected, 20'h0_0064);
        cmd_mag = 16'h0BB8;
        ticks(1);
        check(status.expected, 20'h0_0032);
        check(status.ratio, 16'h012C);
        cmd_mag = 16'h0000;
        ticks(1);
        cfg.dly_type = DLY_FIXED;
        // Phases B and C together: combined per-phase start and their own events
        ev_q.delete();
        t0 = timestamp[7:0];
        cmd_phases = 3'h6;
        cmd_mag = 16'h05DC;
        ticks(1);
        check(status.phase_start, 3'h6);
        check_ev(t0, '{ev(EV_START, 1'b1), ev(EV_START_B, 1'b1),
            ev(EV_START_C, 1'b1)});
        cmd_mag = 16'h0000;
        cmd_phases = 3'h1;
        ticks(1);
        // Clear counters between ticks, then overfill the record ring by one
        cnt_clear = 1'b1;
        idle(1);
        cnt_clear = 1'b0;
        idle(1);
        check(counts, '0);
        for (int i = 0; i < 13; i++) begin
            ts_q.push_back(timestamp[7:0]);
            cmd_mag = 16'h05DC;
            ticks(1);
            cmd_mag = 16'h0000;
            ticks(1);
        end
        check(log_count, 4'hC);
        check(counts.starts, 16'h000D);
        log_sel = 4'hB;
        idle(2);
        check(log_rec.stamp[7:0], ts_q[1]);
        log_sel = 4'h0;
        idle(2);
        check(log_rec.stamp[7:0], ts_q[12]);
        check(log_rec.pre_trig, 16'h05DC);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
